// >>> raf_conv_src.sv
// raf_conv_src: converter-side model that offers one conversion at a time to the filter.
// assumes convReady is a registered filter output sampled at rising edges of sys_clk.
`timescale 1ns/1ps
`default_nettype none

module raf_conv_src #(
    parameter int W = 24
) (
    input  wire logic         sys_clk,
    input  wire logic         convReady,
    output var  logic         convValid,
    output var  logic [W-1:0] convData
);
    initial begin
        convValid = 1'h0;
        convData  = {W{1'h0}};
    end

    // offer stays put until taken; after release the data lines show the inverse so no stale copy can pass
    task automatic send(input logic [W-1:0] v);
        @(posedge sys_clk);
        #1;
        convValid = 1'h1;
        convData  = v;
        @(posedge sys_clk);
        while (convReady !== 1'h1) begin
            @(posedge sys_clk);
        end
        #1;
        convValid = 1'h0;
        convData  = ~v;
    endtask
endmodule // raf_conv_src

`default_nettype wire

// >>> raf_divider.sv
// raf_divider: serial signed-by-unsigned divider, one quotient bit a cycle.
// assumes start is a one-cycle pulse and is not raised again before done.
`timescale 1ns/1ps
`default_nettype none

module raf_divider #(
    parameter int W  = 24,
    parameter int SW = W + 7
) (
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire logic          start,
    input  wire logic [SW-1:0] dividend,
    input  wire logic [6:0]    divisor,
    output logic               done,
    output logic [W-1:0]       quotient
);

    localparam int CB = $clog2(SW + 1);

    typedef struct packed {
        logic          busy;
        logic          done;
        logic          neg;
        logic [CB-1:0] cnt;
        logic [7:0]    rem;
        logic [6:0]    div;
        logic [SW-1:0] quo;
        logic [W-1:0]  result;
    } raf_div_t;

    raf_div_t r;
    raf_div_t n;

    always_comb begin
        logic [7:0] t;
        t = 8'h00;
        n = r;
        if (ce) begin
            n.done = 1'b0;
            if (start) begin
                n.busy = 1'b1;
                n.neg  = dividend[SW-1];
                n.quo  = dividend[SW-1] ? (~dividend + 1'b1) : dividend;
                n.rem  = 8'h00;
                n.div  = divisor;
                n.cnt  = CB'(SW);
            end else if (r.busy) begin
                t = {r.rem[6:0], r.quo[SW-1]};
                if (t >= {1'b0, r.div}) begin
                    n.rem = t - {1'b0, r.div};
                    n.quo = {r.quo[SW-2:0], 1'b1};
                end else begin
                    n.rem = t;
                    n.quo = {r.quo[SW-2:0], 1'b0};
                end
                n.cnt = r.cnt - 1'b1;
                if (r.cnt == CB'(1)) begin
                    n.busy   = 1'b0;
                    n.done   = 1'b1;
                    // mean of in-range readings always fits the reading width
                    n.result = r.neg ? W'(~{n.quo} + 1'b1) : W'(n.quo);
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign done     = r.done;
    assign quotient = r.result;

endmodule // raf_divider

`default_nettype wire

// >>> raf_pkg.sv
// raf_pkg: shared constants for the reading average filter.
// assumes a single clock domain; every user of these names writes raf_pkg::name.
//
// Summary of operation
// - each reading is the plain mean of a stack of 1 to 100 conversions.
// - moving mode outputs its first reading only after the stack fills.
// - once full, moving mode drops the oldest conversion and outputs each time.
// - repeating mode averages a full stack, then empties it and starts again.
// - advanced type has a noise window of 0 to 100 percent of range.
// - each enable request toggles the filter; the indicator shows it is on.
// - each function except frequency keeps its own filter configuration.
package raf_pkg;

    localparam int STACK_MIN     = 1;
    localparam int STACK_MAX     = 100;
    localparam int PCT_MAX       = 100;
    localparam int STACK_BITS    = 7;
    // count of cycles a division takes beyond its SW bit steps, counted from its start cycle
    localparam int DIV_EXTRA     = 2;

    localparam logic [6:0] RST_STACK   = 7'h0a;
    localparam logic [6:0] RST_PCT     = 7'h00;
    localparam logic       RST_ADV     = 1'b0;
    localparam logic       RST_REPEAT  = 1'b0;
    localparam logic       RST_ENABLED = 1'b0;

endpackage

// >>> reading_average_filter.sv
// reading_average_filter: averaging filter between the converter and the reading sink.
// assumes conversions are offered only while convReady is high, all inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module reading_average_filter #(
    parameter int W       = 24,
    parameter int NF      = 8,
    parameter int FREQUENCY_FUNCTION_FN = NF - 1
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire logic                  convValid,
    input  wire logic [W-1:0]          convData,
    input  wire logic [$clog2(NF)-1:0] funcSel,
    input  wire logic [W-1:0]          rangeFull,
    input  wire logic                  enableReq,
    input  wire logic                  cfgWrite,
    input  wire logic [$clog2(NF)-1:0] cfgFunc,
    input  wire logic                  cfgAdvanced,
    input  wire logic [6:0]            cfgStack,
    input  wire logic                  cfgRepeat,
    input  wire logic [6:0]            cfgWindowPct,
    output logic                       convReady,
    output logic                       readingValid,
    output logic [W-1:0]               readingData,
    output logic                       filter_active_indicator
);

    localparam int SW = W + 7;
    localparam int PW = SW + 7;
    localparam int FW = $clog2(NF);
    localparam int SM = raf_pkg::STACK_MAX;
    localparam int DIV_LIM = SW + raf_pkg::DIV_EXTRA;

    typedef enum logic {RAF_IDLE, RAF_DIVIDE} raf_state_t;

    typedef struct packed {
        raf_state_t           st;
        logic                 enabled;
        logic [FW-1:0]        lastFunc;
        logic [NF-1:0]        adv;
        logic [NF-1:0]        rpt;
        logic [NF-1:0][6:0]   size;
        logic [NF-1:0][6:0]   pct;
        logic [SM-1:0][W-1:0] stack;
        logic [6:0]           wrPtr;
        logic [6:0]           count;
        logic [SW-1:0]        sum;
        logic [W-1:0]         avg;
        logic                 avgValid;
        logic                 divStart;
        logic                 ready;
        logic                 flushPend;
        logic                 rdValid;
        logic [W-1:0]         rdData;
    } raf_st_t;

    raf_st_t r;
    raf_st_t n;

    logic          divDone;
    logic [W-1:0]  divQuot;

    function automatic logic [SW-1:0] sext(input logic [W-1:0] v);
        sext = {{(SW-W){v[W-1]}}, v};
    endfunction

    // the noise window compares |x - avg| * 100 against range * pct, avoiding a divide
    function automatic logic beyond_window(input logic [W-1:0] x, input logic [W-1:0] a,
                                           input logic [W-1:0] rng, input logic [6:0] p);
        logic [SW-1:0] d;
        logic [PW-1:0] lhs;
        logic [PW-1:0] rhs;
        d   = sext(x) - sext(a);
        d   = d[SW-1] ? (~d + 1'b1) : d;
        lhs = PW'(d) * PW'(raf_pkg::PCT_MAX);
        rhs = PW'(rng) * PW'(p);
        beyond_window = lhs > rhs;
    endfunction

    raf_divider #(
        .W  (W),
        .SW (SW)
    ) u_div (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .ce       (ce),
        .start    (r.divStart),
        .dividend (r.sum),
        .divisor  (r.size[r.lastFunc]),
        .done     (divDone),
        .quotient (divQuot)
    );

    logic       convTaken;
    logic       filtering;
    logic       flushEvt;
    logic [6:0] curSize;

    assign curSize   = r.size[funcSel];
    assign convTaken = ce && convValid && r.ready && (r.st == RAF_IDLE) && (funcSel == r.lastFunc);
    assign filtering = r.enabled && (funcSel != FW'(FREQUENCY_FUNCTION_FN));
    assign flushEvt  = convTaken && filtering && r.adv[funcSel] && r.avgValid
                       && beyond_window(convData, r.avg, rangeFull, r.pct[funcSel]);

    always_comb begin
        logic       restart;
        logic [6:0] cnt1;
        logic [6:0] ptr1;
        restart = 1'b0;
        cnt1    = 7'h00;
        ptr1    = 7'h00;
        n       = r;
        if (ce) begin
            n.rdValid  = 1'b0;
            n.divStart = 1'b0;
            if (cfgWrite && cfgFunc != FW'(FREQUENCY_FUNCTION_FN)
                && cfgStack >= 7'(raf_pkg::STACK_MIN) && cfgStack <= 7'(raf_pkg::STACK_MAX)
                && cfgWindowPct <= 7'(raf_pkg::PCT_MAX)) begin
                n.adv[cfgFunc]  = cfgAdvanced;
                n.rpt[cfgFunc]  = cfgRepeat;
                n.size[cfgFunc] = cfgStack;
                n.pct[cfgFunc]  = cfgWindowPct;
                restart = (cfgFunc == r.lastFunc);
            end
            if (enableReq) begin
                n.enabled = ~r.enabled;
                restart   = 1'b1;
            end
            if (funcSel != r.lastFunc) begin
                restart = 1'b1;
            end
            case (r.st)
                RAF_IDLE: begin
                    n.ready = 1'b1;
                    if (convTaken && !filtering) begin
                        n.rdValid = 1'b1;
                        n.rdData  = convData;
                    end else if (flushEvt) begin
                        n.stack[0] = convData;
                        n.wrPtr    = (curSize == 7'h01) ? 7'h00 : 7'h01;
                        n.count    = 7'h01;
                        n.sum      = sext(convData);
                        n.avg      = convData;
                        if (curSize == 7'h01) begin
                            n.st       = RAF_DIVIDE;
                            n.divStart = 1'b1;
                            n.ready    = 1'b0;
                            if (r.rpt[funcSel]) begin
                                n.count = 7'h00;
                            end
                        end
                    end else if (convTaken) begin
                        ptr1 = (r.wrPtr + 7'h01 >= curSize) ? 7'h00 : r.wrPtr + 7'h01;
                        n.stack[r.wrPtr] = convData;
                        n.wrPtr          = ptr1;
                        if (r.count < curSize) begin
                            cnt1  = r.count + 7'h01;
                            n.sum = r.sum + sext(convData);
                        end else begin
                            // oldest slot is the one overwritten
                            cnt1  = r.count;
                            n.sum = r.sum + sext(convData) - sext(r.stack[r.wrPtr]);
                        end
                        n.count = cnt1;
                        // average only once stack is full
                        if (cnt1 == curSize) begin
                            n.st       = RAF_DIVIDE;
                            n.divStart = 1'b1;
                            n.ready    = 1'b0;
                        end
                    end
                end
                RAF_DIVIDE: begin
                    n.ready = 1'b0;
                    if (divDone) begin
                        n.rdValid  = 1'b1;
                        n.rdData   = divQuot;
                        n.avg      = divQuot;
                        n.avgValid = 1'b1;
                        n.st       = RAF_IDLE;
                        n.ready    = 1'b1;
                        // repeating empties the stack after each reading
                        if (r.rpt[r.lastFunc]) begin
                            n.count = 7'h00;
                            n.wrPtr = 7'h00;
                            n.sum   = '0;
                        end
                    end
                end
                default: n.st = RAF_IDLE;
            endcase
            // a new function or setting must not mix readings of two configurations
            // a flush asked for mid-divide is held until the divide ends, else a pulse would be lost
            if (restart || r.flushPend) begin
                if (r.st == RAF_DIVIDE && !divDone) begin
                    n.flushPend = 1'b1;
                end else begin
                    n.flushPend = 1'b0;
                    n.count     = 7'h00;
                    n.wrPtr     = 7'h00;
                    n.sum       = '0;
                    n.avgValid  = 1'b0;
                    n.lastFunc  = funcSel;
                    n.ready     = 1'b0;
                    n.divStart  = 1'b0;
                    n.st        = RAF_IDLE;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r          <= '0;
            r.st       <= RAF_IDLE;
            r.enabled  <= raf_pkg::RST_ENABLED;
            r.adv      <= {NF{raf_pkg::RST_ADV}};
            r.rpt      <= {NF{raf_pkg::RST_REPEAT}};
            r.size     <= {NF{raf_pkg::RST_STACK}};
            r.pct      <= {NF{raf_pkg::RST_PCT}};
        end else begin
            r <= n;
        end
    end

    assign convReady               = r.ready;
    assign readingValid            = r.rdValid;
    assign readingData             = r.rdData;
    assign filter_active_indicator = r.enabled;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence sDivStart;
        ce && r.st == RAF_IDLE && n.st == RAF_DIVIDE;
    endsequence

    sequence sDivFinish;
        ce && r.st == RAF_DIVIDE && divDone;
    endsequence

    a_pass_through: assert property (convTaken && !filtering && !enableReq |=>
        readingValid && readingData == $past(convData))
        else $error("disabled conversion not passed through");
    a_enable_toggle: assert property (ce && enableReq |=>
        filter_active_indicator != $past(filter_active_indicator))
        else $error("enable request did not toggle the filter");
    a_stack_bound: assert property (r.count <= 7'(raf_pkg::STACK_MAX))
        else $error("stack count above maximum");
    a_div_bounded: assert property (sDivStart |-> ##[1:DIV_LIM] sDivFinish)
        else $error("average not produced in time");
    a_no_early_out: assert property (r.st == RAF_DIVIDE && !divDone |=> !readingValid || !ce)
        else $error("reading emitted before the average was ready");
    a_repeat_clear: assert property (sDivFinish ##0 r.rpt[r.lastFunc] && !enableReq && funcSel == r.lastFunc
        |=> r.count == 7'h00 && r.sum == '0)
        else $error("repeating stack not emptied");
    a_moving_full: assert property (sDivFinish ##0 !r.rpt[r.lastFunc] && !enableReq && !cfgWrite
        && funcSel == r.lastFunc && !r.flushPend |=> r.count == r.size[r.lastFunc])
        else $error("moving stack lost its fill");
    a_window_flush: assert property (flushEvt && !enableReq && !cfgWrite |=> r.count <= 7'h01)
        else $error("step beyond window did not flush the stack");
    a_cfg_reject: assert property (ce && cfgWrite && cfgStack == 7'h00 |=>
        r.size[$past(cfgFunc)] == $past(r.size[cfgFunc]))
        else $error("invalid stack size was accepted");

endmodule // reading_average_filter

`default_nettype wire

// >>> reading_average_filter_tb.sv
// reading_average_filter_tb: directed tests of averaging modes, noise window, per-function setup, pass-through.
// assumes raf_conv_src and the design files are compiled first; ce is high except in one freeze check.
`timescale 1ns/1ps
`default_nettype none

module reading_average_filter_tb;
    localparam int W = 24;

    logic         sys_clk      = 1'h0;
    logic         resetn       = 1'h0;
    logic         ce           = 1'h1;
    logic         convValid;
    logic [W-1:0] convData;
    logic [2:0]   funcSel      = 3'h0;
    logic [W-1:0] rangeFull    = 24'h0003e8;
    logic         enableReq    = 1'h0;
    logic         cfgWrite     = 1'h0;
    logic [2:0]   cfgFunc      = 3'h0;
    logic         cfgAdvanced  = 1'h0;
    logic [6:0]   cfgStack     = 7'h0a;
    logic         cfgRepeat    = 1'h0;
    logic [6:0]   cfgWindowPct = 7'h00;
    logic         convReady;
    logic         readingValid;
    logic [W-1:0] readingData;
    logic         filterOn;
    logic [W-1:0] lastRd       = 24'h000000;
    int           rdCount      = 0;
    int           expCnt       = 0;
    int           err_count    = 0;
    int           checked      = 0;

    always #2.5 sys_clk = ~sys_clk;

    reading_average_filter #(.W(W), .NF(8)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .convValid(convValid), .convData(convData),
        .funcSel(funcSel), .rangeFull(rangeFull), .enableReq(enableReq), .cfgWrite(cfgWrite),
        .cfgFunc(cfgFunc), .cfgAdvanced(cfgAdvanced), .cfgStack(cfgStack), .cfgRepeat(cfgRepeat),
        .cfgWindowPct(cfgWindowPct), .convReady(convReady), .readingValid(readingValid),
        .readingData(readingData), .filter_active_indicator(filterOn)
    );

    raf_conv_src #(.W(W)) i_src (
        .sys_clk(sys_clk), .convReady(convReady), .convValid(convValid), .convData(convData)
    );

    // readingValid stands one cycle, so every pulse is caught at its edge
    always @(posedge sys_clk) begin
        if (readingValid === 1'h1) begin
            rdCount <= rdCount + 1;
            lastRd  <= readingData;
        end
    end

    task automatic chk(input string name, input logic [W-1:0] exp, input logic [W-1:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one conversion, then wait out any divide before looking at the reading count and value
    task automatic step(input int v, input int dn, input int mean);
        int n;
        n = 0;
        i_src.send(v[W-1:0]);
        @(posedge sys_clk);
        while (convReady !== 1'h1 && n < 80) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (2) @(posedge sys_clk);
        #1;
        expCnt += dn;
        chk("readingCount", expCnt[W-1:0], rdCount[W-1:0]);
        if (dn != 0) begin
            chk("readingData", mean[W-1:0], lastRd);
        end
    endtask

    task automatic cfg(input logic [2:0] f, input logic a, input logic [6:0] s, input logic r, input logic [6:0] p);
        cfgFunc      = f;
        cfgAdvanced  = a;
        cfgStack     = s;
        cfgRepeat    = r;
        cfgWindowPct = p;
        cfgWrite     = 1'h1;
        @(posedge sys_clk);
        #1;
        cfgWrite = 1'h0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic sel(input logic [2:0] f);
        funcSel = f;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic toggle_en(input logic exp);
        enableReq = 1'h1;
        @(posedge sys_clk);
        #1;
        enableReq = 1'h0;
        @(posedge sys_clk);
        #1;
        chk("indicator", {{(W-1){1'h0}}, exp}, {{(W-1){1'h0}}, filterOn});
    endtask

    task automatic tally_and_finish;
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        chk("indicatorReset", 24'h000000, {23'h000000, filterOn});
        resetn = 1'h1;
        step(32'h00123456, 1, 32'h00123456);
        toggle_en(1'h1);
        cfg(3'h0, 1'h0, 7'h03, 1'h0, 7'h00);
        step(-1, 0, 0);
        step(-1, 0, 0);
        step(0, 1, 0);
        step(9, 1, 2);
        step(12, 1, 7);
        cfg(3'h1, 1'h0, 7'h02, 1'h1, 7'h00);
        sel(3'h1);
        step(4, 0, 0);
        step(6, 1, 5);
        step(100, 0, 0);
        step(2, 1, 51);
        sel(3'h0);
        step(3, 0, 0);
        step(6, 0, 0);
        step(9, 1, 6);
        sel(3'h7);
        step(77, 1, 77);
        cfg(3'h0, 1'h0, 7'h00, 1'h0, 7'h00);
        cfg(3'h0, 1'h0, 7'h65, 1'h0, 7'h00);
        sel(3'h0);
        step(1, 0, 0);
        step(1, 0, 0);
        step(4, 1, 2);
        cfg(3'h2, 1'h0, 7'h01, 1'h0, 7'h00);
        sel(3'h2);
        step(-5, 1, -5);
        cfg(3'h3, 1'h1, 7'h04, 1'h0, 7'h0a);
        sel(3'h3);
        step(100, 0, 0);
        step(100, 0, 0);
        step(100, 0, 0);
        step(100, 1, 100);
        step(500, 0, 0);
        step(500, 0, 0);
        step(500, 0, 0);
        step(500, 1, 500);
        toggle_en(1'h0);
        step(33, 1, 33);
        // an enable request while ce is low must leave the filter untouched
        ce        = 1'h0;
        enableReq = 1'h1;
        @(posedge sys_clk);
        #1;
        enableReq = 1'h0;
        ce        = 1'h1;
        @(posedge sys_clk);
        #1;
        chk("indicatorFrozen", 24'h000000, {23'h000000, filterOn});
        tally_and_finish();
    end

    // the tests take some 500 cycles; twelve times that means a hang
    initial begin
        #30000;
        err_count++;
        tally_and_finish();
    end
endmodule // reading_average_filter_tb

`default_nettype wire
